/* hw/seq_pkg.sv */
// Shared constants for the panel supply start-up sequencer
package seq_pkg;
  // Ramp peaks in a full start-up
  localparam int PEAKS_TOTAL = 6;
  // Peak counts at which each phase begins (count of completed peaks)
  localparam int PEAK_REF_ON = 1;
  localparam int PEAK_STEPUP_START = 2;
  localparam int PEAK_STEPUP_CHECK = 3;
  localparam int PEAK_NEG_ON = 3;
  localparam int PEAK_POS_START = 5;
  localparam int PEAK_GATE_CHECK = 6;
  // Nominal timing with 100nF on the timing capacitor
  localparam int SOFT_START_US = 7000;
  localparam int FAULT_TIMEOUT_US = 23000;
  localparam int CLOCK_MHZ = 250;
  localparam int SOFT_START_CYCLES = SOFT_START_US * CLOCK_MHZ;
  localparam int FAULT_TIMEOUT_CYCLES = FAULT_TIMEOUT_US * CLOCK_MHZ;
  // Shaping output switch selection
  typedef enum logic [1:0] {
    SHAPE_GROUND,
    SHAPE_LOW,
    SHAPE_HIGH
  } shape_sel_t;
endpackage

/* hw/shape_selector.sv */
// Three-way selector for the gate-shaping output
`timescale 1ns/100ps
module shape_selector (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic seq_done,
  input wire logic latched_off,
  input wire logic slice_select_input,
  output seq_pkg::shape_sel_t sel,
  output logic to_ground,
  output logic to_low_level_input,
  output logic to_high_level_supply_input
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel <= seq_pkg::SHAPE_GROUND;
    end else if (ce) begin
      // R18 grounded until ready
      if (!seq_done || latched_off) begin
        sel <= seq_pkg::SHAPE_GROUND;
      // R14 select gated by completion
      end else if (slice_select_input) begin
        // R16 high side
        sel <= seq_pkg::SHAPE_HIGH;
      end else begin
        // R15 low side
        sel <= seq_pkg::SHAPE_LOW;
      end
    end
  end

  // R13 exactly one switch closed
  always_comb begin
    to_ground = 1'b0;
    to_low_level_input = 1'b0;
    to_high_level_supply_input = 1'b0;
    case (sel)
      seq_pkg::SHAPE_LOW: to_low_level_input = 1'b1;
      seq_pkg::SHAPE_HIGH: to_high_level_supply_input = 1'b1;
      default: to_ground = 1'b1;
    endcase
  end
endmodule

/* hw/panel_supply_startup_sequencer.sv */
// Start-up sequencer and fault latch for a panel supply device
`timescale 1ns/100ps
// What this block does
// R01 - Six ramp peaks on the timing node make a full start-up.
// R02 - Any fault latches off until activate toggles or supply cycles.
// R03 - Timing capacitor charges only once input supply exceeds 2.4V.
// R04 - First slow ramp checks for faults; proceed only if none.
// R05 - After a clean first peak, discharge the timing capacitor.
// R06 - Reference switches on at the first ramp peak.
// R07 - Step-up converter stays disabled during early ramps.
// R08 - Step-up soft-starts at third ramp start, checked at its end.
// R09 - Soft-start lasts about 7ms with nominal capacitor.
// R10 - Negative gate rail switches on at the fourth ramp start.
// R11 - Positive gate rail on at sixth ramp; both gates checked after.
// R12 - Fault time-out about 23ms at nominal capacitor, scales with it. The code counts a fixed FAULT_TIMEOUT_CYCLES of clock cycles instead.
// R13 - Shaping output connects to exactly one of three sources.
// R14 - Select input ignored until start-up completes.
// R15 - Select low connects shaping output to low-level input.
// R16 - Select high connects shaping output to high-level supply.
// R17 - Over-temperature latches off until supply or activate cycles.
// R18 - Shaping output grounded before completion and while latched off.
// R19 - Latch-off disables all rails and clears the peak count.
module panel_supply_startup_sequencer #(
  parameter int PEAKS = seq_pkg::PEAKS_TOTAL,
  parameter int SOFT_START_CYCLES = seq_pkg::SOFT_START_CYCLES,
  parameter int FAULT_TIMEOUT_CYCLES = seq_pkg::FAULT_TIMEOUT_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic CHIP_ACTIVATE,
  input wire logic SUPPLY_ABOVE_2V4,
  input wire logic TIMING_RAMP_PEAK,
  input wire logic INPUT_FAULT,
  input wire logic STEP_UP_RAIL_FAULT,
  input wire logic NEGATIVE_GATE_RAIL_FAULT,
  input wire logic POSITIVE_GATE_RAIL_FAULT,
  input wire logic OVER_TEMPERATURE,
  input wire logic SLICE_SELECT_INPUT,
  output logic TIMING_CHARGE_EN,
  output logic TIMING_DISCHARGE,
  output logic REFERENCE_EN,
  output logic STEP_UP_EN,
  output logic STEP_UP_SOFT_START,
  output logic NEGATIVE_GATE_RAIL_EN,
  output logic POSITIVE_GATE_RAIL_EN,
  output logic SEQUENCE_DONE,
  output logic LATCHED_OFF,
  output logic [2:0] PEAK_COUNT,
  output logic SHAPE_TO_GROUND,
  output logic SHAPE_TO_LOW_LEVEL_INPUT,
  output logic SHAPE_TO_HIGH_LEVEL_SUPPLY_INPUT
);
  // Count width and phase thresholds are sized for six peaks
  if (PEAKS != seq_pkg::PEAKS_TOTAL) begin : g_check_peaks
    $error("PEAKS must equal six");
  end
  if (SOFT_START_CYCLES < 1) begin : g_check_soft
    $error("SOFT_START_CYCLES must be at least one");
  end
  if (FAULT_TIMEOUT_CYCLES < 1) begin : g_check_timeout
    $error("FAULT_TIMEOUT_CYCLES must be at least one");
  end

  typedef enum logic [1:0] {IDLE, RAMPING, DONE, OFF} seq_state_t;
  seq_state_t state;
  logic activate_d;
  logic peak_d;
  logic peak_rise;
  logic fault_now;
  logic [31:0] soft_cnt;
  logic [31:0] fault_cnt;
  logic fault_pending;
  logic run_ok;
  logic activate_fall;
  logic ramp_ok;
  logic done_ok;
  logic first_ramp;
  logic stepup_check;
  logic gate_check;
  logic gate_fault;
  logic rail_fault_any;
  logic stepup_watch;
  logic timeout_hit;

  // Count has reached a phase threshold
  function automatic logic reached(input logic [2:0] count,
      input int threshold);
    reached = (count >= 3'(threshold));
  endfunction

  // Peak that ends the ramp numbered by the argument
  function automatic logic closing_ramp(input logic [2:0] count,
      input int peak);
    closing_ramp = (count == 3'(peak - 1));
  endfunction

  assign peak_rise = TIMING_RAMP_PEAK && !peak_d;
  // Activate and supply both good; either dropping ends the run
  assign run_ok = CHIP_ACTIVATE && SUPPLY_ABOVE_2V4;
  // High-then-low activate; a low level alone does not release
  assign activate_fall = !CHIP_ACTIVATE && activate_d;
  assign ramp_ok = (state == RAMPING) && run_ok && !fault_now;
  assign done_ok = (state == DONE) && run_ok && !fault_now;
  assign first_ramp = (state == RAMPING) && (PEAK_COUNT == 3'h0);
  assign stepup_check = (state == RAMPING) && peak_rise
    && closing_ramp(PEAK_COUNT, seq_pkg::PEAK_STEPUP_CHECK);
  assign gate_check = (state == RAMPING) && peak_rise
    && closing_ramp(PEAK_COUNT, seq_pkg::PEAK_GATE_CHECK);
  assign gate_fault = NEGATIVE_GATE_RAIL_FAULT || POSITIVE_GATE_RAIL_FAULT;
  assign rail_fault_any = STEP_UP_RAIL_FAULT || gate_fault;
  // Step-up watched once its own check has passed
  assign stepup_watch = (state == RAMPING || state == DONE)
    && reached(PEAK_COUNT, seq_pkg::PEAK_STEPUP_CHECK)
    && STEP_UP_RAIL_FAULT;
  assign timeout_hit = fault_pending
    && (fault_cnt >= 32'(FAULT_TIMEOUT_CYCLES - 1));

  // Faults checked per phase; thermal trip counts at any time
  always_comb begin
    fault_now = OVER_TEMPERATURE;
    // R04 first ramp check
    if (first_ramp && INPUT_FAULT)
      fault_now = 1'b1;
    // R08 step-up checked at end of third ramp
    if (stepup_check && STEP_UP_RAIL_FAULT)
      fault_now = 1'b1;
    // R11 gate rails checked at end of sixth ramp
    if (gate_check && gate_fault)
      fault_now = 1'b1;
    // Once up, any rail fault trips at once
    if (state == DONE && rail_fault_any)
      fault_now = 1'b1;
    // R12 persistent step-up rail fault times out
    if (timeout_hit)
      fault_now = 1'b1;
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      activate_d <= 1'b0;
      peak_d <= 1'b0;
    end else if (CE) begin
      activate_d <= CHIP_ACTIVATE;
      peak_d <= TIMING_RAMP_PEAK;
    end
  end

  // Sequence state
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state <= IDLE;
    end else if (CE) begin
      case (state)
        IDLE: begin
          // R03 charging waits for supply
          if (run_ok)
            state <= RAMPING;
        end
        RAMPING: begin
          // R02 R17 latch off on any fault
          if (fault_now)
            state <= OFF;
          else if (!run_ok)
            state <= IDLE;
          // R01 last counted peak completes start-up
          else if (peak_rise && closing_ramp(PEAK_COUNT, PEAKS))
            state <= DONE;
        end
        DONE: begin
          if (fault_now)
            state <= OFF;
          else if (!run_ok)
            state <= IDLE;
        end
        OFF: begin
          // R02 release on activate toggle or supply drop
          if (activate_fall || !SUPPLY_ABOVE_2V4)
            state <= IDLE;
        end
        default: begin
          state <= IDLE;
        end
      endcase
    end
  end

  // R01 R19 count peaks, clear on exit
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      PEAK_COUNT <= 3'h0;
    end else if (CE) begin
      if (ramp_ok) begin
        if (peak_rise)
          PEAK_COUNT <= PEAK_COUNT + 3'h1;
      end else if (!done_ok) begin
        PEAK_COUNT <= 3'h0;
      end
    end
  end

  // Fault time-out counter while a step-up rail fault persists
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      fault_cnt <= 32'd0;
      fault_pending <= 1'b0;
    end else if (CE) begin
      if (stepup_watch) begin
        fault_pending <= 1'b1;
        fault_cnt <= fault_cnt + 32'd1;
      end else begin
        fault_pending <= 1'b0;
        fault_cnt <= 32'd0;
      end
    end
  end

  // R09 soft-start timer
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      soft_cnt <= 32'd0;
    end else if (CE) begin
      if (!STEP_UP_EN)
        soft_cnt <= 32'd0;
      else if (soft_cnt < 32'(SOFT_START_CYCLES))
        soft_cnt <= soft_cnt + 32'd1;
    end
  end

  // Timing node: charge while ramping, one discharge pulse per peak
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      TIMING_CHARGE_EN <= 1'b0;
      TIMING_DISCHARGE <= 1'b0;
    end else if (CE) begin
      if (ramp_ok) begin
        TIMING_CHARGE_EN <= 1'b1;
        // R05 discharge after each clean peak
        TIMING_DISCHARGE <= peak_rise;
      end else begin
        TIMING_CHARGE_EN <= 1'b0;
        TIMING_DISCHARGE <= 1'b0;
      end
    end
  end

  // Rails hold through DONE; any other exit drops them on the same edge
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      REFERENCE_EN <= 1'b0;
    end else if (CE) begin
      if (ramp_ok) begin
        // R06 reference at first peak
        if (peak_rise || reached(PEAK_COUNT, seq_pkg::PEAK_REF_ON))
          REFERENCE_EN <= 1'b1;
      end else if (!done_ok) begin
        // R19 everything off together
        REFERENCE_EN <= 1'b0;
      end
    end
  end

  // Step-up converter enable
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      STEP_UP_EN <= 1'b0;
    end else if (CE) begin
      if (ramp_ok) begin
        // R07 R08 step-up waits for third ramp
        STEP_UP_EN <= reached(PEAK_COUNT, seq_pkg::PEAK_STEPUP_START);
      end else if (!done_ok) begin
        STEP_UP_EN <= 1'b0;
      end
    end
  end

  // Gate rail enables
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      NEGATIVE_GATE_RAIL_EN <= 1'b0;
      POSITIVE_GATE_RAIL_EN <= 1'b0;
    end else if (CE) begin
      if (ramp_ok) begin
        // R10 negative gate at fourth ramp
        NEGATIVE_GATE_RAIL_EN <= reached(PEAK_COUNT, seq_pkg::PEAK_NEG_ON);
        // R11 positive gate at sixth ramp
        POSITIVE_GATE_RAIL_EN <= reached(PEAK_COUNT, seq_pkg::PEAK_POS_START);
      end else if (!done_ok) begin
        NEGATIVE_GATE_RAIL_EN <= 1'b0;
        POSITIVE_GATE_RAIL_EN <= 1'b0;
      end
    end
  end

  assign STEP_UP_SOFT_START = STEP_UP_EN
    && (soft_cnt < 32'(SOFT_START_CYCLES));
  assign SEQUENCE_DONE = (state == DONE);
  assign LATCHED_OFF = (state == OFF);

  shape_selector u_shape (
    .clk(CLOCK),
    .rst_n(RST_N),
    .ce(CE),
    .seq_done(SEQUENCE_DONE),
    .latched_off(LATCHED_OFF),
    .slice_select_input(SLICE_SELECT_INPUT),
    .sel(),
    .to_ground(SHAPE_TO_GROUND),
    .to_low_level_input(SHAPE_TO_LOW_LEVEL_INPUT),
    .to_high_level_supply_input(SHAPE_TO_HIGH_LEVEL_SUPPLY_INPUT)
  );
endmodule

/* verif/seq_properties.sv */
// Port assertions for the start-up sequencer
`timescale 1ns/100ps
module seq_properties (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic TIMING_RAMP_PEAK,
  input wire logic TIMING_CHARGE_EN,
  input wire logic TIMING_DISCHARGE,
  input wire logic REFERENCE_EN,
  input wire logic STEP_UP_EN,
  input wire logic NEGATIVE_GATE_RAIL_EN,
  input wire logic POSITIVE_GATE_RAIL_EN,
  input wire logic SEQUENCE_DONE,
  input wire logic LATCHED_OFF,
  input wire logic [2:0] PEAK_COUNT,
  input wire logic SLICE_SELECT_INPUT,
  input wire logic SHAPE_TO_GROUND,
  input wire logic SHAPE_TO_LOW_LEVEL_INPUT,
  input wire logic SHAPE_TO_HIGH_LEVEL_SUPPLY_INPUT
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // Enables lag the count by a cycle, so judge them only while not latched
  sequence peak_seen;
    TIMING_CHARGE_EN && !LATCHED_OFF && $rose(TIMING_RAMP_PEAK);
  endsequence
  sequence rails_off;
    !(REFERENCE_EN || STEP_UP_EN) &&
    !(NEGATIVE_GATE_RAIL_EN || POSITIVE_GATE_RAIL_EN);
  endsequence
  a_ref_after_peak: assert property (
    REFERENCE_EN && !LATCHED_OFF |-> PEAK_COUNT != 3'h0)
    else $error("reference before first peak");
  a_stepup_late: assert property (
    STEP_UP_EN && !LATCHED_OFF |-> PEAK_COUNT >= 3'h2)
    else $error("step-up enabled early");
  a_neg_order: assert property (
    NEGATIVE_GATE_RAIL_EN && !LATCHED_OFF |-> PEAK_COUNT >= 3'h3)
    else $error("negative rail early");
  a_pos_order: assert property (
    POSITIVE_GATE_RAIL_EN && !LATCHED_OFF |-> PEAK_COUNT >= 3'h5)
    else $error("positive rail early");
  a_peak_discharge: assert property (
    peak_seen |=> TIMING_DISCHARGE || LATCHED_OFF)
    else $error("no discharge after peak");
  a_peak_count: assert property (
    peak_seen |=> LATCHED_OFF || PEAK_COUNT == $past(PEAK_COUNT) + 3'h1)
    else $error("peak not counted");
  a_latch_clear: assert property (
    $rose(LATCHED_OFF) |-> PEAK_COUNT == 3'h0 ##1 rails_off)
    else $error("latch left rails or count");
  a_shape_ground: assert property (
    !SEQUENCE_DONE |=> SHAPE_TO_GROUND)
    else $error("shaping not grounded");
  a_select_low: assert property (
    SEQUENCE_DONE && !SLICE_SELECT_INPUT |=> SHAPE_TO_LOW_LEVEL_INPUT)
    else $error("select low not followed");
  a_select_high: assert property (
    SEQUENCE_DONE && SLICE_SELECT_INPUT |=> SHAPE_TO_HIGH_LEVEL_SUPPLY_INPUT)
    else $error("select high not followed");
  a_one_switch: assert property (
    $onehot({SHAPE_TO_GROUND, SHAPE_TO_LOW_LEVEL_INPUT,
      SHAPE_TO_HIGH_LEVEL_SUPPLY_INPUT}))
    else $error("shaping switches not one-hot");
endmodule
bind panel_supply_startup_sequencer seq_properties chk (.*);

/* verif/ramp_model.sv */
// Timing capacitor model: ramps while charging, peak comparator
`timescale 1ns/100ps
module ramp_model (
  input wire logic clk,
  input wire logic charge_en,
  input wire logic discharge,
  input wire logic [7:0] ramp_len,
  output logic peak
);
  logic [7:0] level = 8'h00;
  // Level holds at the top until discharged, as a real capacitor would
  always @(posedge clk) begin
    if (discharge || !charge_en)
      level <= 8'h00;
    else if (level < ramp_len)
      level <= level + 8'h01;
  end
  assign peak = charge_en && (level >= ramp_len);
endmodule

/* verif/tb_top.sv */
// Self-checking bench for the start-up sequencer
`timescale 1ns/100ps
module tb_top;
  logic clock, rst_n, ce, act, sup, in_f, su_f, ng_f, pg_f, ot, sel;
  logic peak, chg, dis, ref_en, su_en, ss, ng_en, pg_en, done, off;
  logic gnd, lo, hi;
  logic [2:0] cnt, last;
  int n_mismatch, n_tests, np, nss;
  panel_supply_startup_sequencer #(.SOFT_START_CYCLES(20),
    .FAULT_TIMEOUT_CYCLES(30)) dut (.CLOCK(clock), .RST_N(rst_n),
    .CE(ce), .CHIP_ACTIVATE(act), .SUPPLY_ABOVE_2V4(sup),
    .TIMING_RAMP_PEAK(peak), .INPUT_FAULT(in_f),
    .STEP_UP_RAIL_FAULT(su_f), .NEGATIVE_GATE_RAIL_FAULT(ng_f),
    .POSITIVE_GATE_RAIL_FAULT(pg_f), .OVER_TEMPERATURE(ot),
    .SLICE_SELECT_INPUT(sel), .TIMING_CHARGE_EN(chg),
    .TIMING_DISCHARGE(dis), .REFERENCE_EN(ref_en), .STEP_UP_EN(su_en),
    .STEP_UP_SOFT_START(ss), .NEGATIVE_GATE_RAIL_EN(ng_en),
    .POSITIVE_GATE_RAIL_EN(pg_en), .SEQUENCE_DONE(done),
    .LATCHED_OFF(off), .PEAK_COUNT(cnt), .SHAPE_TO_GROUND(gnd),
    .SHAPE_TO_LOW_LEVEL_INPUT(lo), .SHAPE_TO_HIGH_LEVEL_SUPPLY_INPUT(hi));
  ramp_model partner (.clk(clock), .charge_en(chg), .discharge(dis),
    .ramp_len(8'h28), .peak(peak));
  initial begin
    clock = 0;
    forever #2 clock = ~clock;
  end
  task results;
    $display("mismatches %0d tests %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Runs until done or latched, noting peaks and soft-start length
  task run;
    int i;
    logic pp;
    np = 0;
    nss = 0;
    pp = 0;
    for (i = 0; i < 3000 && done !== 1'b1 && off !== 1'b1; i++) begin
      if (peak && !pp) np++;
      if (ss === 1'b1) nss++;
      pp = peak;
      last = cnt;
      tick(1);
    end
    if (i == 3000) begin
      n_mismatch++;
      results();
    end
  endtask
  task t_startup;
    act = 1;
    sel = 1;
    tick(10);
    chk(chg === 1'b0, "ramp below supply");
    sup = 1;
    run();
    chk(done === 1'b1 && np == 6 && cnt === 3'h6, "peaks");
    chk(nss == 20, "soft start");
    chk({ref_en, su_en, ng_en, pg_en, gnd} === 5'h1F, "rails");
    tick(2);
    chk(hi === 1'b1 && gnd === 1'b0, "select high");
    sel = 0;
    tick(2);
    chk(lo === 1'b1 && hi === 1'b0, "select low");
  endtask
  task t_thermal;
    ot = 1;
    tick(1);
    ot = 0;
    tick(1);
    chk({off, ref_en, gnd, cnt} === 6'h28, "thermal latch");
    act = 0;
    tick(2);
    chk(off === 1'b0, "activate toggle");
  endtask
  task t_stepup_fault;
    su_f = 1;
    act = 1;
    run();
    chk(off === 1'b1 && last === 3'h2, "step-up check");
    tick(1);
    chk({ref_en, su_en, ng_en, pg_en, gnd} === 5'h01, "latched");
    su_f = 0;
    tick(20);
    chk(off === 1'b1, "latch held");
    act = 0;
    tick(2);
    act = 1;
    in_f = 1;
    run();
    chk(off === 1'b1 && last === 3'h0 && np == 0, "input fault");
    in_f = 0;
    sup = 0;
    tick(2);
    chk(off === 1'b0, "supply cycle");
  endtask
  task t_gate_faults;
    for (int k = 0; k < 2; k++) begin
      {ng_f, pg_f} = k ? 2'b10 : 2'b01;
      sup = 1;
      run();
      chk(off === 1'b1 && last === 3'h5, "gate check");
      sup = 0;
      tick(2);
    end
  endtask
  // Step-up fault after its check passes trips on the time-out
  task t_timeout;
    int i;
    {ng_f, pg_f} = 2'b00;
    sup = 1;
    for (i = 0; i < 1000 && cnt !== 3'h3; i++)
      tick(1);
    if (i == 1000) begin
      n_mismatch++;
      results();
    end
    su_f = 1;
    tick(29);
    chk(off === 1'b0 && cnt === 3'h3, "early time-out");
    tick(1);
    chk(off === 1'b1 && cnt === 3'h0, "time-out latch");
    su_f = 0;
    sup = 0;
    tick(2);
  endtask
  initial begin
    {rst_n, act, sup, in_f, su_f, ng_f, pg_f, ot, sel} = '0;
    ce = 1;
    n_mismatch = 0;
    n_tests = 0;
    repeat (6) @(posedge clock);
    #1 rst_n = 1;
    tick(1);
    t_startup();
    t_thermal();
    t_stepup_fault();
    t_gate_faults();
    t_timeout();
    results();
  end
endmodule
